// file: hdl/cpesd_pkg.sv
// constants and types shared by the event-select decode block
package cpesd_pkg;

    // event codes
    localparam logic [7:0] EC_SECOND_LEVEL = 8'h24;
    localparam logic [7:0] EC_STORE_LOCK = 8'h27;
    localparam logic [7:0] EC_WRITEBACK = 8'h28;
    localparam logic [7:0] EC_LAST_LEVEL = 8'h2e;
    localparam logic [7:0] EC_UNHALTED = 8'h3c;
    localparam logic [7:0] EC_DATA_MISS = 8'h48;
    localparam logic [7:0] EC_STORE_WALK = 8'h49;

    // unit masks
    localparam logic [7:0] UM_00 = 8'h00;
    localparam logic [7:0] UM_01 = 8'h01;
    localparam logic [7:0] UM_02 = 8'h02;
    localparam logic [7:0] UM_04 = 8'h04;
    localparam logic [7:0] UM_08 = 8'h08;
    localparam logic [7:0] UM_0F = 8'h0f;
    localparam logic [7:0] UM_10 = 8'h10;
    localparam logic [7:0] UM_20 = 8'h20;
    localparam logic [7:0] UM_30 = 8'h30;
    localparam logic [7:0] UM_40 = 8'h40;
    localparam logic [7:0] UM_41 = 8'h41;
    localparam logic [7:0] UM_4F = 8'h4f;
    localparam logic [7:0] UM_80 = 8'h80;
    localparam logic [7:0] UM_C0 = 8'hc0;

    // second-level line states carried with store-lock and writeback requests
    localparam logic [1:0] LINE_SHARED = 2'h1;
    localparam logic [1:0] LINE_EXCLUSIVE = 2'h2;
    localparam logic [1:0] LINE_MODIFIED = 2'h3;

    // widths and reset values
    localparam int AMOUNT_W = 4;
    localparam int COUNT_W = 48;
    localparam logic [47:0] COUNT_RESET = 48'h0;

    // reference clock: figures in MHz, divide ratio derived from them
    localparam int CORE_CLK_MHZ = 200;
    localparam int REF_CLK_MHZ = 100;
    localparam int REF_DIV = CORE_CLK_MHZ / REF_CLK_MHZ;
    localparam logic [3:0] REF_DIV_LAST = 4'(REF_DIV - 1);

    // selected event; the order follows the decode table
    typedef enum logic [4:0] {
        SEL_NONE, SEL_CODE_HIT, SEL_CODE_MISS, SEL_CODE_ALL, SEL_PF_HIT,
        SEL_PF_MISS, SEL_PF_ALL, SEL_LOCK_MISS, SEL_LOCK_HIT_E, SEL_LOCK_HIT_M,
        SEL_LOCK_ANY, SEL_WB_MISS, SEL_WB_HIT_S, SEL_WB_HIT_E, SEL_WB_HIT_M,
        SEL_WB_ANY, SEL_LL_REF, SEL_LL_MISS, SEL_UNHALT_THREAD, SEL_UNHALT_REF,
        SEL_DATA_MISS, SEL_WALK_START, SEL_WALK_DONE, SEL_WALK_CYCLES
    } cpesd_sel_t;

endpackage : cpesd_pkg

// file: hdl/cpesd_ref_tick.sv
// divider that marks the reference clock rate on the core clock
`timescale 1ns/1ps
`default_nettype none
module cpesd_ref_tick
    import cpesd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    output logic tick
);

    logic [3:0] phase;

    ////////////////////////////////////////////////////////////////////////
    // free-running phase; the tick marks the last phase of each ref period
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            phase <= 4'h0;
        else if (ce)
        begin
            if (phase == REF_DIV_LAST)
                phase <= 4'h0;
            else
                phase <= phase + 4'h1;
        end
    end

    // combinational so the increment register samples the tick in the same cycle
    assign tick = (phase == REF_DIV_LAST);

endmodule : cpesd_ref_tick
`default_nettype wire

// file: hdl/cpesd_threshold.sv
// count threshold and edge detection applied to a per-cycle amount
`timescale 1ns/1ps
`default_nettype none
module cpesd_threshold
    import cpesd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic active,
    input wire logic [AMOUNT_W-1:0] raw,
    input wire logic [7:0] threshold,
    input wire logic edge_en,
    output logic [AMOUNT_W-1:0] amount
);

    logic above;
    logic above_prev;

    // a zero threshold passes the raw amount through unchanged
    assign above = ({4'h0, raw} >= threshold);

    ////////////////////////////////////////////////////////////////////////
    // previous comparison; cleared while the event is not selected so the
    // first pending cycle after selection counts as an occurrence
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            above_prev <= 1'b0;
        else if (ce)
            above_prev <= active & above;
    end

    always_comb
    begin
        if (threshold == 8'h00)
            amount = raw;
        else if (edge_en)
            amount = {3'h0, above & ~above_prev};
        else
            amount = {3'h0, above};
    end

endmodule : cpesd_threshold
`default_nettype wire

// file: hdl/cpesd_top.sv
// performance event selection decode with its event counter
// Behaviour
// RL1: code 24H mask 10H counts instruction fetches hitting second-level cache
// RL2: code 24H mask 20H counts instruction fetches missing second-level cache
// RL3: code 24H mask 30H counts all second-level code requests
// RL4: code 24H mask 40H counts second-level prefetcher requests that hit
// RL5: code 24H mask 80H counts second-level prefetcher requests that miss
// RL6: code 24H mask C0H counts every second-level prefetcher request
// RL7: code 27H mask 01H counts store-lock ownership requests that miss
// RL8: code 27H masks 04H/08H count ownership hits on exclusive/modified lines
// RL9: code 27H mask 0FH counts ownership requests in any line state
// RL10: code 28H mask 01H counts accepted data writebacks missing second level
// RL11: code 28H masks 02H/04H/08H count accepted writeback hits by line state
// RL12: code 28H mask 0FH counts all accepted writebacks, never rejected ones
// RL13: code 2EH mask 4FH counts core requests referencing last-level lines
// RL14: code 2EH mask 41H counts each last-level cache miss condition
// RL15: code 3CH mask 00H counts every thread cycle outside halt
// RL16: code 3CH mask 01H counts at 100 MHz reference rate while unhalted
// RL17: code 48H mask 01H adds outstanding data misses; general counter two only
// RL18: threshold 1 gives cycles with misses pending; edge gives occurrences
// RL19: code 49H mask 01H counts store translation misses starting a walk
// RL20: code 49H mask 02H counts store translation walks that complete
// RL21: code 49H mask 04H counts cycles the walker is busy for stores
// RL22: any unlisted code and mask pairing produces no increments
`timescale 1ns/1ps
`default_nettype none
module cpesd_top
    import cpesd_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [7:0] EVENT_CODE,
    input wire logic [7:0] UNIT_MASK,
    input wire logic ON_GENERAL_COUNTER_TWO,
    input wire logic [7:0] COUNT_THRESHOLD,
    input wire logic EDGE_DETECT,
    input wire logic COUNT_CLEAR,
    input wire logic CODE_REQ_VALID,
    input wire logic CODE_REQ_HIT,
    input wire logic PF_REQ_VALID,
    input wire logic PF_REQ_HIT,
    input wire logic LOCK_REQ_VALID,
    input wire logic LOCK_REQ_HIT,
    input wire logic [1:0] LOCK_REQ_STATE,
    input wire logic WB_REQ_VALID,
    input wire logic WB_REQ_REJECTED,
    input wire logic WB_REQ_HIT,
    input wire logic [1:0] WB_REQ_STATE,
    input wire logic LL_REF_VALID,
    input wire logic LL_MISS_VALID,
    input wire logic THREAD_HALTED,
    input wire logic [AMOUNT_W-1:0] DATA_MISS_OUTSTANDING,
    input wire logic STORE_WALK_START,
    input wire logic STORE_WALK_DONE,
    input wire logic PAGE_MISS_HANDLER_STORE_BUSY,
    output logic SELECT_VALID,
    output logic [AMOUNT_W-1:0] INC_AMOUNT,
    output logic [COUNT_W-1:0] COUNT,
    output logic COUNT_WRAP
);

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // maps a code and mask pairing onto one selected event
    function automatic cpesd_sel_t decode_select(
        input logic [7:0] code,
        input logic [7:0] mask,
        input logic on_two
    );
        cpesd_sel_t sel;
        sel = SEL_NONE;
        unique case (code)
            EC_SECOND_LEVEL:
            begin
                if (mask == UM_10) sel = SEL_CODE_HIT;
                if (mask == UM_20) sel = SEL_CODE_MISS;
                if (mask == UM_30) sel = SEL_CODE_ALL;
                if (mask == UM_40) sel = SEL_PF_HIT;
                if (mask == UM_80) sel = SEL_PF_MISS;
                if (mask == UM_C0) sel = SEL_PF_ALL;
            end
            EC_STORE_LOCK:
            begin
                if (mask == UM_01) sel = SEL_LOCK_MISS;
                if (mask == UM_04) sel = SEL_LOCK_HIT_E;
                if (mask == UM_08) sel = SEL_LOCK_HIT_M;
                if (mask == UM_0F) sel = SEL_LOCK_ANY;
            end
            EC_WRITEBACK:
            begin
                if (mask == UM_01) sel = SEL_WB_MISS;
                if (mask == UM_02) sel = SEL_WB_HIT_S;
                if (mask == UM_04) sel = SEL_WB_HIT_E;
                if (mask == UM_08) sel = SEL_WB_HIT_M;
                if (mask == UM_0F) sel = SEL_WB_ANY;
            end
            EC_LAST_LEVEL:
            begin
                if (mask == UM_4F) sel = SEL_LL_REF;
                if (mask == UM_41) sel = SEL_LL_MISS;
            end
            EC_UNHALTED:
            begin
                if (mask == UM_00) sel = SEL_UNHALT_THREAD;
                if (mask == UM_01) sel = SEL_UNHALT_REF;
            end
            EC_DATA_MISS:
            begin
                // only the second general counter carries this event
                if (mask == UM_01 && on_two) sel = SEL_DATA_MISS;
            end
            EC_STORE_WALK:
            begin
                if (mask == UM_01) sel = SEL_WALK_START;
                if (mask == UM_02) sel = SEL_WALK_DONE;
                if (mask == UM_04) sel = SEL_WALK_CYCLES;
            end
            default:
            begin
                sel = SEL_NONE;
            end
        endcase
        return sel;
    endfunction : decode_select

    // a request hits a line in the wanted state
    function automatic logic hit_in_state(
        input logic valid,
        input logic hit,
        input logic [1:0] state,
        input logic [1:0] wanted
    );
        return valid & hit & (state == wanted);
    endfunction : hit_in_state

    // widens a one-bit event to the increment width
    function automatic logic [AMOUNT_W-1:0] one(input logic ev);
        return {3'h0, ev};
    endfunction : one

    ////////////////////////////////////////////////////////////////////////
    // selection register

    cpesd_sel_t sel;
    cpesd_sel_t next_sel;

    assign next_sel = decode_select(EVENT_CODE, UNIT_MASK, ON_GENERAL_COUNTER_TWO);

    // registered so a mid-cycle change of code or mask never yields a mixed count
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            sel <= SEL_NONE;
        else if (CE)
            sel <= next_sel;
    end

    // selection status seen by software
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            SELECT_VALID <= 1'b0;
        else if (CE)
            SELECT_VALID <= (next_sel != SEL_NONE); // RL22
    end

    ////////////////////////////////////////////////////////////////////////
    // reference rate and pending-miss threshold

    logic ref_tick;
    logic data_miss_sel;
    logic [AMOUNT_W-1:0] data_miss_amount;

    cpesd_ref_tick u_ref_tick (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .ce(CE),
        .tick(ref_tick)
    );

    assign data_miss_sel = (sel == SEL_DATA_MISS);

    // threshold and edge apply only to the pending-miss event here
    cpesd_threshold u_threshold (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .ce(CE),
        .active(data_miss_sel),
        .raw(DATA_MISS_OUTSTANDING),
        .threshold(COUNT_THRESHOLD),
        .edge_en(EDGE_DETECT),
        .amount(data_miss_amount) // RL18
    );

    ////////////////////////////////////////////////////////////////////////
    // per-cycle increment for the selected event

    logic wb_accepted;
    logic unhalted;
    logic [AMOUNT_W-1:0] next_inc;

    // rejected writebacks never reach any of the writeback counts
    assign wb_accepted = WB_REQ_VALID & ~WB_REQ_REJECTED; // RL12
    assign unhalted = ~THREAD_HALTED;

    always_comb
    begin
        next_inc = '0;
        unique case (sel)
            SEL_NONE:
            begin
                next_inc = '0; // RL22
            end
            SEL_CODE_HIT:
            begin
                next_inc = one(CODE_REQ_VALID & CODE_REQ_HIT); // RL1
            end
            SEL_CODE_MISS:
            begin
                next_inc = one(CODE_REQ_VALID & ~CODE_REQ_HIT); // RL2
            end
            SEL_CODE_ALL:
            begin
                next_inc = one(CODE_REQ_VALID); // RL3
            end
            SEL_PF_HIT:
            begin
                next_inc = one(PF_REQ_VALID & PF_REQ_HIT); // RL4
            end
            SEL_PF_MISS:
            begin
                next_inc = one(PF_REQ_VALID & ~PF_REQ_HIT); // RL5
            end
            SEL_PF_ALL:
            begin
                next_inc = one(PF_REQ_VALID); // RL6
            end
            SEL_LOCK_MISS:
            begin
                next_inc = one(LOCK_REQ_VALID & ~LOCK_REQ_HIT); // RL7
            end
            SEL_LOCK_HIT_E:
            begin
                next_inc = one(hit_in_state(LOCK_REQ_VALID, LOCK_REQ_HIT,
                    LOCK_REQ_STATE, LINE_EXCLUSIVE)); // RL8
            end
            SEL_LOCK_HIT_M:
            begin
                next_inc = one(hit_in_state(LOCK_REQ_VALID, LOCK_REQ_HIT,
                    LOCK_REQ_STATE, LINE_MODIFIED)); // RL8
            end
            SEL_LOCK_ANY:
            begin
                next_inc = one(LOCK_REQ_VALID); // RL9
            end
            SEL_WB_MISS:
            begin
                next_inc = one(wb_accepted & ~WB_REQ_HIT); // RL10
            end
            SEL_WB_HIT_S:
            begin
                next_inc = one(hit_in_state(wb_accepted, WB_REQ_HIT,
                    WB_REQ_STATE, LINE_SHARED)); // RL11
            end
            SEL_WB_HIT_E:
            begin
                next_inc = one(hit_in_state(wb_accepted, WB_REQ_HIT,
                    WB_REQ_STATE, LINE_EXCLUSIVE)); // RL11
            end
            SEL_WB_HIT_M:
            begin
                next_inc = one(hit_in_state(wb_accepted, WB_REQ_HIT,
                    WB_REQ_STATE, LINE_MODIFIED)); // RL11
            end
            SEL_WB_ANY:
            begin
                next_inc = one(wb_accepted); // RL12
            end
            SEL_LL_REF:
            begin
                next_inc = one(LL_REF_VALID); // RL13
            end
            SEL_LL_MISS:
            begin
                next_inc = one(LL_MISS_VALID); // RL14
            end
            SEL_UNHALT_THREAD:
            begin
                next_inc = one(unhalted); // RL15
            end
            SEL_UNHALT_REF:
            begin
                // the tick keeps running during halt, so rate stays fixed
                next_inc = one(unhalted & ref_tick); // RL16
            end
            SEL_DATA_MISS:
            begin
                next_inc = data_miss_amount; // RL17
            end
            SEL_WALK_START:
            begin
                next_inc = one(STORE_WALK_START); // RL19
            end
            SEL_WALK_DONE:
            begin
                next_inc = one(STORE_WALK_DONE); // RL20
            end
            SEL_WALK_CYCLES:
            begin
                next_inc = one(PAGE_MISS_HANDLER_STORE_BUSY); // RL21
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // increment register

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            INC_AMOUNT <= '0;
        else if (CE)
            INC_AMOUNT <= next_inc;
    end

    ////////////////////////////////////////////////////////////////////////
    // event counter

    logic [COUNT_W:0] next_sum;

    // one extra bit catches the wrap without a second adder
    assign next_sum = {1'b0, COUNT} + {{(COUNT_W - AMOUNT_W + 1){1'b0}}, INC_AMOUNT};

    // a clear drops the increment of that cycle; software clears when idle
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            COUNT <= COUNT_RESET;
        else if (CE)
        begin
            if (COUNT_CLEAR)
                COUNT <= COUNT_RESET;
            else
                COUNT <= next_sum[COUNT_W-1:0];
        end
    end

    // one-cycle mark when the counter passes its top value
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            COUNT_WRAP <= 1'b0;
        else if (CE)
            COUNT_WRAP <= next_sum[COUNT_W] & ~COUNT_CLEAR;
    end

endmodule : cpesd_top
`default_nettype wire

// file: verification/cpesd_top_assertions.sv
// concurrent checks on the ports of the event-select decode block
`timescale 1ns/1ps
`default_nettype none
module cpesd_top_checker
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [7:0] EVENT_CODE,
    input wire logic [7:0] UNIT_MASK,
    input wire logic ON_GENERAL_COUNTER_TWO,
    input wire logic [7:0] COUNT_THRESHOLD,
    input wire logic COUNT_CLEAR,
    input wire logic CODE_REQ_VALID,
    input wire logic CODE_REQ_HIT,
    input wire logic WB_REQ_VALID,
    input wire logic WB_REQ_REJECTED,
    input wire logic THREAD_HALTED,
    input wire logic [cpesd_pkg::AMOUNT_W-1:0] DATA_MISS_OUTSTANDING,
    input wire logic PAGE_MISS_HANDLER_STORE_BUSY,
    input wire logic SELECT_VALID,
    input wire logic [cpesd_pkg::AMOUNT_W-1:0] INC_AMOUNT,
    input wire logic [cpesd_pkg::COUNT_W-1:0] COUNT,
    input wire logic COUNT_WRAP
);
    import cpesd_pkg::*;
    logic [7:0] cur_code;
    logic [7:0] cur_mask;
    logic cur_two;
    logic [15:0] cur_sel;

    // pairings that must enable counting; the pending-miss one only on counter two
    function automatic logic listed(input logic [7:0] c, input logic [7:0] m, input logic two);
        case ({c, m})
            16'h2410, 16'h2420, 16'h2430, 16'h2440, 16'h2480, 16'h24c0: listed = 1'b1;
            16'h2701, 16'h2704, 16'h2708, 16'h270f: listed = 1'b1;
            16'h2801, 16'h2802, 16'h2804, 16'h2808, 16'h280f: listed = 1'b1;
            16'h2e4f, 16'h2e41, 16'h3c00, 16'h3c01, 16'h4901, 16'h4902, 16'h4904: listed = 1'b1;
            16'h4801: listed = two;
            default: listed = 1'b0;
        endcase
    endfunction : listed

    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the selection, taken on enabled edges like the design's own
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cur_code <= 8'h00;
            cur_mask <= 8'h00;
            cur_two <= 1'b0;
        end
        else if (CE)
        begin
            cur_code <= EVENT_CODE;
            cur_mask <= UNIT_MASK;
            cur_two <= ON_GENERAL_COUNTER_TWO;
        end
    end
    assign cur_sel = {cur_code, cur_mask};

    ////////////////////////////////////////////////////////////////////////////////
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    select_match_a: assert property (SELECT_VALID == listed(cur_code, cur_mask, cur_two))
        else $error("selection flag disagrees with the pairing");
    unlisted_zero_a: assert property (CE && !SELECT_VALID |=> INC_AMOUNT == 4'h0)
        else $error("increment without a valid selection");
    code_hit_a: assert property (CE && cur_sel == 16'h2410 && CODE_REQ_VALID && CODE_REQ_HIT |=> INC_AMOUNT == 4'h1)
        else $error("code hit not counted");
    code_miss_a: assert property (CE && cur_sel == 16'h2420 && CODE_REQ_VALID
        |=> INC_AMOUNT == {3'h0, !$past(CODE_REQ_HIT)})
        else $error("code miss count wrong");
    wb_reject_a: assert property (CE && cur_code == 8'h28 && WB_REQ_VALID && WB_REQ_REJECTED |=> INC_AMOUNT == 4'h0)
        else $error("rejected writeback counted");
    unhalted_a: assert property (CE && cur_sel == 16'h3c00 |=> INC_AMOUNT == {3'h0, !$past(THREAD_HALTED)})
        else $error("unhalted cycle count wrong");
    ref_rate_a: assert property ((CE && cur_sel == 16'h3c01 && !THREAD_HALTED) [*2]
        |=> INC_AMOUNT + $past(INC_AMOUNT) == 4'h1)
        else $error("reference rate not one in two cycles");
    pending_raw_a: assert property (CE && cur_sel == 16'h4801 && cur_two && COUNT_THRESHOLD == 8'h00
        |=> INC_AMOUNT == $past(DATA_MISS_OUTSTANDING))
        else $error("pending miss amount wrong");
    walk_busy_a: assert property (CE && cur_sel == 16'h4904 |=> INC_AMOUNT == {3'h0, $past(PAGE_MISS_HANDLER_STORE_BUSY)})
        else $error("walker busy cycle count wrong");
    count_add_a: assert property (CE && !COUNT_CLEAR |=> COUNT == $past(COUNT) + 48'($past(INC_AMOUNT)))
        else $error("counter did not add the increment");
    wrap_quiet_a: assert property (CE && !COUNT_CLEAR && COUNT < 48'hffff_ffff_fff0 |=> !COUNT_WRAP)
        else $error("wrap mark without the counter passing its top");

endmodule : cpesd_top_checker

bind cpesd_top cpesd_top_checker cpesd_top_checker_inst (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE),
    .EVENT_CODE(EVENT_CODE), .UNIT_MASK(UNIT_MASK), .ON_GENERAL_COUNTER_TWO(ON_GENERAL_COUNTER_TWO),
    .COUNT_THRESHOLD(COUNT_THRESHOLD), .COUNT_CLEAR(COUNT_CLEAR), .CODE_REQ_VALID(CODE_REQ_VALID),
    .CODE_REQ_HIT(CODE_REQ_HIT), .WB_REQ_VALID(WB_REQ_VALID), .WB_REQ_REJECTED(WB_REQ_REJECTED),
    .THREAD_HALTED(THREAD_HALTED), .DATA_MISS_OUTSTANDING(DATA_MISS_OUTSTANDING),
    .PAGE_MISS_HANDLER_STORE_BUSY(PAGE_MISS_HANDLER_STORE_BUSY), .SELECT_VALID(SELECT_VALID),
    .INC_AMOUNT(INC_AMOUNT), .COUNT(COUNT), .COUNT_WRAP(COUNT_WRAP));
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the event-select decode block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cpesd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] code = 8'h00;
    logic [7:0] mask = 8'h00;
    logic two = 1'b1;
    logic [7:0] thr = 8'h00;
    logic edge_en = 1'b0;
    logic clr = 1'b0;
    logic ce = 1'b1;
    logic [23:0] ev = 24'h0;
    logic select_valid;
    logic [AMOUNT_W-1:0] inc_amount;
    logic [COUNT_W-1:0] count;
    logic count_wrap;
    logic [15:0] sum;
    int fails = 0;
    int cmp_count = 0;
    // code, mask, event vector, expected increment
    logic [43:0] rows [36] = '{
        44'h2410_000003_1, 44'h2410_000001_0, 44'h2420_000001_1, 44'h2420_000003_0,
        44'h2430_000003_1, 44'h2430_000001_1, 44'h2440_00000c_1, 44'h2440_000004_0,
        44'h2480_000004_1, 44'h24c0_00000c_1, 44'h2701_000010_1, 44'h2704_0000b0_1,
        44'h2704_0000f0_0, 44'h2708_0000f0_1, 44'h270f_000070_1, 44'h270f_000010_1,
        44'h2801_000100_1, 44'h2802_000d00_1, 44'h2804_001500_1, 44'h2808_001d00_1,
        44'h2808_001f00_0, 44'h280f_001500_1, 44'h2e4f_002000_1, 44'h2e41_004000_1,
        44'h2e41_002000_0, 44'h3c00_040000_1, 44'h3c00_000000_0, 44'h4801_280000_5,
        44'h4901_008000_1, 44'h4902_010000_1, 44'h4904_020000_1, 44'h4904_008000_0,
        44'h2401_000003_0, 44'h3c02_040000_0, 44'h4800_280000_0, 44'h2e40_006000_0
    };

    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz core clock
    always #2.5 clk_sys = ~clk_sys;

    // event vector split onto the request inputs; bit 18 high means not halted
    cpesd_top cpesd_top_inst (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .EVENT_CODE(code), .UNIT_MASK(mask),
        .ON_GENERAL_COUNTER_TWO(two), .COUNT_THRESHOLD(thr), .EDGE_DETECT(edge_en), .COUNT_CLEAR(clr),
        .CODE_REQ_VALID(ev[0]), .CODE_REQ_HIT(ev[1]), .PF_REQ_VALID(ev[2]), .PF_REQ_HIT(ev[3]),
        .LOCK_REQ_VALID(ev[4]), .LOCK_REQ_HIT(ev[5]), .LOCK_REQ_STATE(ev[7:6]), .WB_REQ_VALID(ev[8]),
        .WB_REQ_REJECTED(ev[9]), .WB_REQ_HIT(ev[10]), .WB_REQ_STATE(ev[12:11]), .LL_REF_VALID(ev[13]),
        .LL_MISS_VALID(ev[14]), .THREAD_HALTED(~ev[18]), .DATA_MISS_OUTSTANDING(ev[22:19]),
        .STORE_WALK_START(ev[15]), .STORE_WALK_DONE(ev[16]), .PAGE_MISS_HANDLER_STORE_BUSY(ev[17]),
        .SELECT_VALID(select_valid), .INC_AMOUNT(inc_amount), .COUNT(count), .COUNT_WRAP(count_wrap));

    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    // inputs move 1 ns after the rising edge so no race with the design's sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    // selection is taken at the next edge, events start the cycle after
    task automatic pick(input logic [7:0] c, input logic [7:0] m);
        code = c;
        mask = m;
        ev = 24'h0;
        step(1);
    endtask : pick

    task automatic accum(input int n);
        sum = 16'h0;
        repeat (n)
        begin
            step(1);
            sum = sum + 16'(inc_amount);
        end
    endtask : accum

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: table first, then reference rate, threshold, refusal and counter
    initial
    begin
        step(20);
        chk(48'(select_valid), 48'h0, "select in reset");
        chk(count, 48'h0, "count in reset");
        rst_b = 1'b1;
        step(2);
        foreach (rows[i])
        begin
            pick(rows[i][43:36], rows[i][35:28]);
            ev = rows[i][27:4];
            step(1);
            chk(48'(inc_amount), 48'(rows[i][3:0]), "table increment");
            chk(48'(select_valid), 48'(i < 32), "table select");
            ev = 24'h0;
        end
        pick(8'h3c, 8'h01);
        ev = 24'h040000;
        accum(20);
        chk(48'(sum), 48'(20 / REF_DIV), "reference rate");
        thr = 8'h01;
        pick(8'h48, 8'h01);
        ev = 24'h180000;
        accum(6);
        chk(48'(sum), 48'h6, "pending cycles");
        ev = 24'h0;
        edge_en = 1'b1;
        step(2);
        ev = 24'h180000;
        accum(6);
        chk(48'(sum), 48'h1, "pending occurrences");
        thr = 8'h00;
        edge_en = 1'b0;
        two = 1'b0;
        pick(8'h48, 8'h01);
        ev = 24'h280000;
        step(1);
        chk(48'(select_valid), 48'h0, "counter two only");
        chk(48'(inc_amount), 48'h0, "counter two only amount");
        two = 1'b1;
        pick(8'h24, 8'h30);
        clr = 1'b1;
        step(1);
        clr = 1'b0;
        ev = 24'h000001;
        step(5);
        ev = 24'h0;
        step(1);
        chk(count, 48'h5, "back to back code requests");
        // a low enable must hold the counter even with requests arriving
        ce = 1'b0;
        ev = 24'h000001;
        step(3);
        chk(count, 48'h5, "frozen by enable");
        ce = 1'b1;
        step(2);
        chk(count, 48'h6, "resumed after enable");
        chk(48'(count_wrap), 48'h0, "no wrap mark");
        // second reset in mid-run, selection left standing
        rst_b = 1'b0;
        step(1);
        chk(count, 48'h0, "count in mid-run reset");
        chk(48'(select_valid), 48'h0, "select in mid-run reset");
        rst_b = 1'b1;
        step(2);
        chk(48'(select_valid), 48'h1, "select after release");
        chk(count, 48'h0, "count after release");
        wrap_up();
    end

    // the whole run is well under a thousand cycles; five thousand means a hang
    initial
    begin
        #25000;
        fails++;
        wrap_up();
    end

endmodule : tb_top
`default_nettype wire
